// ---- src/urx_pkg.sv ----
// package: register map, field positions, carriers and constants of the serial receiver
package urx_pkg;

  // ----------------------------------------------------------------
  // register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RCV_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RCV_DATA   = 8'h04;
  localparam logic [7:0] ADDR_DIV_LOW    = 8'h08;
  localparam logic [7:0] ADDR_DIV_HIGH   = 8'h0c;
  localparam logic [7:0] ADDR_BAUD_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_XMT_CTRL   = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1c;

  // ----------------------------------------------------------------
  // receive_status_control fields
  // ----------------------------------------------------------------
  localparam int BIT_PORT_EN  = 7;
  localparam int BIT_NINE_SEL = 6;
  localparam int BIT_CONT_EN  = 4;
  localparam int BIT_ADDR_EN  = 3;
  localparam int BIT_FRAME    = 2;
  localparam int BIT_OVERRUN  = 1;
  localparam int BIT_NINTH    = 0;
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hd8;

  // interrupt status / mask fields
  localparam int IRQ_RECEIVED = 0;
  localparam int IRQ_OVERRUN  = 1;
  localparam int IRQ_WIDTH    = 2;

  // ----------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RESET_CTRL    = 8'h00;
  localparam logic [15:0] RESET_DIVISOR = 16'h0000;
  localparam int          FIFO_DEPTH    = 2;
  localparam int          SAMPLES_BIT   = 16;
  localparam int          SAMPLE_MID    = 8;

  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } urx_state_type;

  // one received character as it enters the fifo
  typedef struct packed {
    logic       frame_err;
    logic [8:0] data;
  } urx_char_type;

  typedef struct packed {
    logic       sel;
    logic       enable;
    logic       write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } urx_apb_req_type;

endpackage : urx_pkg

// ---- src/urx_baud_tick.sv ----
// module: baud rate generator giving sixteen sample ticks per bit
`timescale 1ns/1ps
`default_nettype none

module urx_baud_tick (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        run,
  input  wire logic [15:0] divisor,
  output logic             tick
);
  import urx_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic        tick;
  } urx_baud_st_type;

  urx_baud_st_type st_ff;
  urx_baud_st_type nxt_st;

  always_comb begin
    nxt_st      = st_ff;
    nxt_st.tick = 1'b0;
    // divisor n yields one tick every n+1 clocks
    if (!run) begin
      nxt_st.count = 16'h0000;
    end else if (st_ff.count >= divisor) begin
      nxt_st.count = 16'h0000;
      nxt_st.tick  = 1'b1;
    end else begin
      nxt_st.count = st_ff.count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;

endmodule : urx_baud_tick

`default_nettype wire

// ---- src/urx_char_fifo.sv ----
// module: two-entry character fifo with per-entry framing status
`timescale 1ns/1ps
`default_nettype none

module urx_char_fifo #(
  parameter int DEPTH = 2
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  flush,
  input  wire logic                  push,
  input  wire urx_pkg::urx_char_type push_char,
  input  wire logic                  pop,
  output urx_pkg::urx_char_type      head,
  output logic                       not_empty,
  output logic                       full
);
  import urx_pkg::*;

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    urx_char_type [DEPTH-1:0] mem;
    logic [AW-1:0]            rd;
    logic [AW-1:0]            wr;
    logic [AW:0]              cnt;
  } urx_fifo_st_type;

  urx_fifo_st_type st_ff;
  urx_fifo_st_type nxt_st;

  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction : inc_ptr

  logic do_push;
  logic do_pop;

  always_comb begin
    nxt_st  = st_ff;
    do_pop  = pop && (st_ff.cnt != '0);
    do_push = push && (st_ff.cnt != (AW+1)'(DEPTH));
    if (flush) begin
      nxt_st = '0;
    end else begin
      if (do_push) begin
        nxt_st.mem[st_ff.wr] = push_char;
        nxt_st.wr            = inc_ptr(st_ff.wr);
      end
      if (do_pop) begin
        nxt_st.rd = inc_ptr(st_ff.rd);
      end
      if (do_push && !do_pop) begin
        nxt_st.cnt = st_ff.cnt + (AW+1)'(1);
      end else if (do_pop && !do_push) begin
        nxt_st.cnt = st_ff.cnt - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign head      = (st_ff.cnt != '0) ? st_ff.mem[st_ff.rd] : '0;
  assign not_empty = (st_ff.cnt != '0);
  assign full      = (st_ff.cnt == (AW+1)'(DEPTH));

endmodule : urx_char_fifo

`default_nettype wire

// ---- src/urx_receiver.sv ----
// module: serial receiver with framing, overrun, nine-bit and address-detect handling, apb slave
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE_01 - framing flag kept per fifo character
// RULE_02 - missing stop bit sets framing error
// RULE_03 - software reads framing flag before data
// RULE_04 - reception continues; data read advances flag
// RULE_05 - port disable clears flag; continuous-disable keeps it
// RULE_06 - framing error never raises interrupt
// RULE_07 - two-deep fifo; third character sets overrun; one completing in a data-read cycle is dropped without overrun
// RULE_08 - overrun blocks reception until enable cleared
// RULE_09 - nine-bit option shifts nine data bits
// RULE_10 - ninth bit of oldest character shown
// RULE_11 - address mode keeps only ninth-bit-set characters; code filters only when the nine-bit option is also set
// RULE_12 - software toggles address mode around messages
// RULE_13 - start, data lsb first, one stop
module urx_receiver (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rx_line,
  output logic             irq
);
  import urx_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    urx_state_type        rx_state;
    logic [3:0]           sample_cnt;
    logic [3:0]           bit_cnt;
    logic [8:0]           shift;
    logic [7:0]           ctrl;
    logic                 overrun;
    logic [15:0]          divisor;
    logic [7:0]           baud_ctrl;
    logic [7:0]           xmt_ctrl;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [31:0]          rdata;
    logic                 rx_meta;
    logic                 rx_sync;
    logic                 rd_wait;
  } urx_st_type;

  urx_st_type st_ff;
  urx_st_type nxt_st;

  urx_char_type head;
  urx_char_type push_char;
  logic         fifo_not_empty;
  logic         fifo_full;
  logic         push;
  logic         pop;
  logic         flush;
  logic         tick;
  logic         port_en;
  logic         cont_en;
  logic         rd_access;
  logic         rd_take;
  logic         wr_access;
  logic         addr_hit;
  logic         char_done;
  logic         char_keep;

  assign port_en   = st_ff.ctrl[BIT_PORT_EN];
  assign cont_en   = st_ff.ctrl[BIT_CONT_EN];
  assign rd_access = psel && penable && !pwrite;
  assign wr_access = psel && penable && pwrite;
  // reads insert one wait state: data is captured in a flop in the first access
  // cycle and then stands on prdata at the edge that completes the transfer
  assign rd_take   = rd_access && !st_ff.rd_wait;
  assign pready    = !rd_take;
  assign pslverr   = psel && penable && !addr_hit;
  assign prdata    = st_ff.rdata;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_RCV_CTRL) || (a == ADDR_RCV_DATA) || (a == ADDR_DIV_LOW) ||
                (a == ADDR_DIV_HIGH) || (a == ADDR_BAUD_CTRL) || (a == ADDR_XMT_CTRL) ||
                (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK);
  endfunction : is_mapped

  assign addr_hit = is_mapped(paddr);

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  urx_baud_tick u_baud (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (port_en),
    .divisor (st_ff.divisor),
    .tick    (tick)
  );

  // a disabled port flushes the fifo so the framing flag reads low
  assign flush = !port_en;                                                   // see RULE_05
  assign pop   = rd_take && (paddr == ADDR_RCV_DATA);                        // see RULE_04

  urx_char_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .flush     (flush),
    .push      (push),
    .push_char (push_char),
    .pop       (pop),
    .head      (head),
    .not_empty (fifo_not_empty),
    .full      (fifo_full)
  );

  // ----------------------------------------------------------------
  // character completion
  // ----------------------------------------------------------------
  // stop bit sampled one bit time after the last data sample, mid stop bit; low there is a framing error
  assign char_done = tick && (st_ff.rx_state == RX_STOP) && (st_ff.sample_cnt == 4'(SAMPLES_BIT - 1));
  assign char_keep = !(st_ff.ctrl[BIT_ADDR_EN] && st_ff.ctrl[BIT_NINE_SEL] && !st_ff.shift[8]); // see RULE_11
  assign push_char = {!st_ff.rx_sync,                                        // see RULE_02
                      (st_ff.ctrl[BIT_NINE_SEL] ? st_ff.shift : {1'b0, st_ff.shift[8:1]})};
  // overrun freezes intake; the fifo only sees characters while it has room
  assign push = char_done && char_keep && cont_en && !st_ff.overrun && !fifo_full; // see RULE_08

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st         = st_ff;
    nxt_st.rx_meta = rx_line;
    nxt_st.rx_sync = st_ff.rx_meta;

    // receive sequencer, sixteen ticks per bit
    if (!port_en || !cont_en) begin
      nxt_st.rx_state   = RX_IDLE;
      nxt_st.sample_cnt = 4'h0;
    end else if (tick) begin
      nxt_st.sample_cnt = st_ff.sample_cnt + 4'h1;
      case (st_ff.rx_state)
        RX_IDLE: begin
          nxt_st.sample_cnt = 4'h0;
          if (!st_ff.rx_sync) begin
            nxt_st.rx_state = RX_START;
          end
        end
        RX_START: begin
          if (st_ff.sample_cnt == 4'(SAMPLE_MID - 1)) begin
            if (st_ff.rx_sync) begin
              nxt_st.rx_state = RX_IDLE;
            end else begin
              nxt_st.rx_state   = RX_DATA;
              nxt_st.sample_cnt = 4'h0;
              nxt_st.bit_cnt    = 4'h0;
            end
          end
        end
        RX_DATA: begin
          if (st_ff.sample_cnt == 4'(SAMPLES_BIT - 1)) begin
            // lsb first: each bit enters at the top and moves down
            nxt_st.shift   = {st_ff.rx_sync, st_ff.shift[8:1]};              // see RULE_13
            nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
            // nine bits when the nine-bit option is set, else eight
            if (st_ff.bit_cnt == (st_ff.ctrl[BIT_NINE_SEL] ? 4'h8 : 4'h7)) begin // see RULE_09
              nxt_st.rx_state   = RX_STOP;
              nxt_st.sample_cnt = 4'h0;
            end
          end
        end
        RX_STOP: begin
          if (st_ff.sample_cnt == 4'(SAMPLES_BIT - 1)) begin
            nxt_st.rx_state = RX_IDLE;
          end
        end
        default: begin
          nxt_st.rx_state = RX_IDLE;
        end
      endcase
    end

    // third whole character with a full fifo
    if (char_done && char_keep && cont_en && fifo_full && !pop) begin        // see RULE_07
      nxt_st.overrun = 1'b1;
    end
    if (!port_en || !cont_en) begin                                          // see RULE_08
      nxt_st.overrun = 1'b0;
    end

    // register writes
    if (wr_access) begin
      if (paddr == ADDR_RCV_CTRL) begin
        nxt_st.ctrl = pwdata[7:0] & CTRL_WRITE_MASK;
      end else if (paddr == ADDR_DIV_LOW) begin
        nxt_st.divisor[7:0] = pwdata[7:0];
      end else if (paddr == ADDR_DIV_HIGH) begin
        nxt_st.divisor[15:8] = pwdata[7:0];
      end else if (paddr == ADDR_BAUD_CTRL) begin
        nxt_st.baud_ctrl = pwdata[7:0];
      end else if (paddr == ADDR_XMT_CTRL) begin
        nxt_st.xmt_ctrl = pwdata[7:0];
      end else if (paddr == ADDR_IRQ_MASK) begin
        nxt_st.irq_mask = pwdata[IRQ_WIDTH-1:0];
      end
    end

    // read clears status; a new event in the same cycle wins
    if (rd_take && (paddr == ADDR_IRQ_STATUS)) begin
      nxt_st.irq_status = '0;
    end
    // framing errors feed no status bit at all
    if (push) begin                                                          // see RULE_06
      nxt_st.irq_status[IRQ_RECEIVED] = 1'b1;
    end
    if (nxt_st.overrun && !st_ff.overrun) begin
      nxt_st.irq_status[IRQ_OVERRUN] = 1'b1;
    end

    // read data, captured in the first access cycle and held through the wait state
    nxt_st.rdata   = rd_access ? st_ff.rdata : 32'h0000_0000;
    nxt_st.rd_wait = rd_take;
    if (rd_take) begin
      nxt_st.rdata = 32'h0000_0000;
      if (paddr == ADDR_RCV_CTRL) begin
        // framing and ninth-bit flags always describe the oldest unread character; overrun is not per character
        nxt_st.rdata[7:0] = st_ff.ctrl;
        nxt_st.rdata[BIT_FRAME]   = head.frame_err;                          // see RULE_01
        nxt_st.rdata[BIT_OVERRUN] = st_ff.overrun;
        nxt_st.rdata[BIT_NINTH]   = head.data[8];                            // see RULE_10
      end else if (paddr == ADDR_RCV_DATA) begin
        nxt_st.rdata[7:0] = head.data[7:0];
      end else if (paddr == ADDR_DIV_LOW) begin
        nxt_st.rdata[7:0] = st_ff.divisor[7:0];
      end else if (paddr == ADDR_DIV_HIGH) begin
        nxt_st.rdata[7:0] = st_ff.divisor[15:8];
      end else if (paddr == ADDR_BAUD_CTRL) begin
        nxt_st.rdata[7:0] = st_ff.baud_ctrl;
      end else if (paddr == ADDR_XMT_CTRL) begin
        nxt_st.rdata[7:0] = st_ff.xmt_ctrl;
      end else if (paddr == ADDR_IRQ_STATUS) begin
        nxt_st.rdata[IRQ_WIDTH-1:0] = st_ff.irq_status;
      end else if (paddr == ADDR_IRQ_MASK) begin
        nxt_st.rdata[IRQ_WIDTH-1:0] = st_ff.irq_mask;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff          <= '0;
      st_ff.rx_state <= RX_IDLE;
      st_ff.ctrl     <= RESET_CTRL;
      st_ff.divisor  <= RESET_DIVISOR;
      st_ff.rx_meta  <= 1'b1;
      st_ff.rx_sync  <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign irq = |(st_ff.irq_status & st_ff.irq_mask);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_port_off_clears;
    @(posedge pclk) disable iff (!presetn)
      !port_en |=> !head.frame_err && !fifo_not_empty;
  endproperty
  a_port_off_clears: assert property (p_port_off_clears) else $error("port disable left fifo"); // see RULE_05

  property p_cont_off_keeps_frame;
    @(posedge pclk) disable iff (!presetn)
      (port_en && $fell(cont_en) && !$past(pop) && !$past(push)) |-> head.frame_err == $past(head.frame_err);
  endproperty
  a_cont_off_keeps_frame: assert property (p_cont_off_keeps_frame) else $error("framing flag moved"); // see RULE_05

  property p_overrun_blocks;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.overrun && port_en && !pop) |=> $stable(head) && $stable(fifo_not_empty);
  endproperty
  a_overrun_blocks: assert property (p_overrun_blocks) else $error("push during overrun"); // see RULE_08

  property p_overrun_cause;
    @(posedge pclk) disable iff (!presetn)
      (char_done && char_keep && cont_en && port_en && fifo_full && !pop) |=> st_ff.overrun;
  endproperty
  a_overrun_cause: assert property (p_overrun_cause) else $error("overrun missed"); // see RULE_07

  property p_overrun_clear;
    @(posedge pclk) disable iff (!presetn)
      (!cont_en || !port_en) |=> !st_ff.overrun;
  endproperty
  a_overrun_clear: assert property (p_overrun_clear) else $error("overrun not cleared"); // see RULE_08

  property p_addr_filter;
    @(posedge pclk) disable iff (!presetn)
      (push && st_ff.ctrl[BIT_ADDR_EN] && st_ff.ctrl[BIT_NINE_SEL]) |-> push_char.data[8];
  endproperty
  a_addr_filter: assert property (p_addr_filter) else $error("non-address char kept"); // see RULE_11

  property p_frame_from_stop;
    @(posedge pclk) disable iff (!presetn)
      push |-> push_char.frame_err == !$past(rx_line, 2);
  endproperty
  a_frame_from_stop: assert property (p_frame_from_stop) else $error("framing error mismatch"); // see RULE_02

  property p_no_frame_irq;
    @(posedge pclk) disable iff (!presetn)
      (!push && !(nxt_st.overrun && !st_ff.overrun)) |=> !$rose(|st_ff.irq_status);
  endproperty
  a_no_frame_irq: assert property (p_no_frame_irq) else $error("spurious interrupt status"); // see RULE_06

  property p_pop_advances;
    @(posedge pclk) disable iff (!presetn)
      (pop && fifo_full && !push && port_en) |=> fifo_not_empty && !fifo_full;
  endproperty
  a_pop_advances: assert property (p_pop_advances) else $error("pop did not advance"); // see RULE_04

endmodule : urx_receiver

`default_nettype wire

// ---- tb/urx_line_model.sv ----
// remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none

module urx_line_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic pclk,
  output logic      rx_line
);
  // the line is driven high from time zero, so it rests high between frames
  initial begin
    rx_line = 1'b1;
  end

  task automatic hold(input logic lvl, input int n);
    rx_line <= lvl;
    repeat (n) @(posedge pclk);
  endtask : hold

  // stop_ok low drops the stop bit for most of its time to force a framing error
  task automatic send(input logic [8:0] data, input logic nine, input logic stop_ok);
    @(posedge pclk);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      hold(data[i], BIT_CLKS);
    end
    if (stop_ok) begin
      hold(1'b1, BIT_CLKS);
    end else begin
      hold(1'b0, BIT_CLKS * 3 / 4);
      hold(1'b1, BIT_CLKS / 4);
    end
    hold(1'b1, 2 * BIT_CLKS);
  endtask : send
endmodule : urx_line_model
`default_nettype wire

// ---- tb/tb_top.sv ----
// self-checking bench of the serial receiver through its apb registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import urx_pkg::*;

  // divisor 0 gives one sample tick per clock
  localparam int BIT_CLKS = SAMPLES_BIT;
  localparam int LIMIT    = 20000;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_line;
  logic        irq;
  int          errors;
  int          checked;
  int          cycles;
  logic [31:0] v;
  logic        slv;
  logic [7:0]  stor [4] = '{ADDR_DIV_LOW, ADDR_DIV_HIGH, ADDR_BAUD_CTRL, ADDR_XMT_CTRL};

  urx_receiver DUT (
    .pclk    (pclk),
    .presetn (presetn),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .pwdata  (pwdata),
    .prdata  (prdata),
    .pready  (pready),
    .pslverr (pslverr),
    .rx_line (rx_line),
    .irq     (irq)
  );

  urx_line_model #(.BIT_CLKS(BIT_CLKS)) LINE (
    .pclk    (pclk),
    .rx_line (rx_line)
  );

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // read data and slave error are taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp);
  endtask : rd

  task automatic irq_chk(input logic exp);
    @(posedge pclk);
    #1;
    check({31'h0, irq}, {31'h0, exp});
  endtask : irq_chk

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      errors = errors + 1;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    checked = 0;
    cycles = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_RCV_CTRL, {24'h0, RESET_CTRL});
    rd(ADDR_IRQ_STATUS, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    foreach (stor[i]) begin
      rd(stor[i], 32'h0);
      wr(stor[i], 32'h5a);
      rd(stor[i], 32'h5a);
      wr(stor[i], 32'h0);
    end
    wr(ADDR_RCV_CTRL, 32'hff);
    rd(ADDR_RCV_CTRL, 32'hd8);
    wr(ADDR_RCV_CTRL, 32'h0);
    apb(1'b0, 8'h20, 32'h0, v, slv);
    check(v, 32'h0);
    check({31'h0, slv}, 32'h1);
    $display("test registers done");

    wr(ADDR_RCV_CTRL, 32'h90);
    LINE.send(9'h05a, 1'b0, 1'b1);
    LINE.send(9'h0a5, 1'b0, 1'b0);
    irq_chk(1'b0);
    wr(ADDR_IRQ_MASK, 32'h01);
    irq_chk(1'b1);
    rd(ADDR_IRQ_STATUS, 32'h01);
    irq_chk(1'b0);
    rd(ADDR_RCV_CTRL, 32'h90);
    rd(ADDR_RCV_DATA, 32'h5a);
    LINE.send(9'h03c, 1'b0, 1'b1);
    rd(ADDR_RCV_CTRL, 32'h94);
    wr(ADDR_RCV_CTRL, 32'h80);
    rd(ADDR_RCV_CTRL, 32'h84);
    wr(ADDR_RCV_CTRL, 32'h90);
    rd(ADDR_RCV_DATA, 32'ha5);
    rd(ADDR_RCV_CTRL, 32'h90);
    rd(ADDR_RCV_DATA, 32'h3c);
    LINE.send(9'h0f0, 1'b0, 1'b0);
    rd(ADDR_RCV_CTRL, 32'h94);
    wr(ADDR_RCV_CTRL, 32'h00);
    rd(ADDR_RCV_CTRL, 32'h00);
    $display("test framing done");

    wr(ADDR_RCV_CTRL, 32'h90);
    rd(ADDR_IRQ_STATUS, 32'h01);
    LINE.send(9'h011, 1'b0, 1'b1);
    LINE.send(9'h022, 1'b0, 1'b1);
    LINE.send(9'h033, 1'b0, 1'b1);
    rd(ADDR_IRQ_STATUS, 32'h03);
    rd(ADDR_RCV_CTRL, 32'h92);
    rd(ADDR_RCV_DATA, 32'h11);
    rd(ADDR_RCV_DATA, 32'h22);
    LINE.send(9'h044, 1'b0, 1'b1);
    rd(ADDR_IRQ_STATUS, 32'h00);
    rd(ADDR_RCV_CTRL, 32'h92);
    wr(ADDR_RCV_CTRL, 32'h80);
    rd(ADDR_RCV_CTRL, 32'h80);
    wr(ADDR_RCV_CTRL, 32'h90);
    LINE.send(9'h055, 1'b0, 1'b1);
    rd(ADDR_RCV_DATA, 32'h55);
    $display("test overrun done");

    wr(ADDR_RCV_CTRL, 32'hd0);
    LINE.send(9'h1c3, 1'b1, 1'b1);
    rd(ADDR_RCV_CTRL, 32'hd1);
    rd(ADDR_RCV_DATA, 32'hc3);
    wr(ADDR_RCV_CTRL, 32'hd8);
    LINE.send(9'h055, 1'b1, 1'b1);
    LINE.send(9'h1aa, 1'b1, 1'b1);
    rd(ADDR_RCV_CTRL, 32'hd9);
    rd(ADDR_RCV_DATA, 32'haa);
    wr(ADDR_RCV_CTRL, 32'hd0);
    LINE.send(9'h066, 1'b1, 1'b1);
    rd(ADDR_RCV_CTRL, 32'hd0);
    rd(ADDR_RCV_DATA, 32'h66);
    $display("test nine-bit done");
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
